// ---- hw/esr_pkg.sv ----
package esr_pkg;

	localparam int ESR_PFX_SLOTS = 4;
	localparam int ESR_EXT_W = 4;
	localparam int ESR_WIDE_BIT = 3;
	localparam int ESR_DISP_W = 32;
	localparam int ESR_ADDR_W = 64;
	localparam int ESR_APB_AW = 8;

	localparam logic [7:0] ESR_PFX_OPSIZE = 8'h66;
	localparam logic [7:0] ESR_PFX_ADDRSIZE = 8'h67;
	localparam logic [7:0] ESR_PFX_REPNE = 8'hF2;
	localparam logic [7:0] ESR_PFX_REP = 8'hF3;

	localparam logic [ESR_APB_AW-1:0] ESR_CTRL_OFF = 8'h00;
	localparam logic [ESR_APB_AW-1:0] ESR_STATUS_OFF = 8'h04;
	localparam logic [ESR_APB_AW-1:0] ESR_COUNT_OFF = 8'h08;
	localparam logic [ESR_APB_AW-1:0] ESR_WIDE_OFF = 8'h0C;
	localparam logic [ESR_APB_AW-1:0] ESR_EA_LO_OFF = 8'h10;
	localparam logic [ESR_APB_AW-1:0] ESR_EA_HI_OFF = 8'h14;

	localparam int ESR_CTRL_ENABLE_BIT = 0;
	localparam int ESR_CTRL_CLEAR_BIT = 1;
	localparam logic [31:0] ESR_CTRL_RESET = 32'h0000_0001;
	localparam int ESR_ST_OP_LSB = 0;
	localparam int ESR_ST_ADDR_LSB = 2;
	localparam int ESR_ST_MODE_LSB = 4;
	localparam int ESR_ST_DROP_BIT = 8;
	localparam int ESR_ST_WIDE_BIT = 9;

	typedef enum logic [2:0] {
		ESR_MODE_REAL = 3'h0,
		ESR_MODE_V86 = 3'h1,
		ESR_MODE_SYS_MANAGE = 3'h2,
		ESR_MODE_PROT = 3'h3,
		ESR_MODE_COMPAT = 3'h4,
		ESR_MODE_LONG64 = 3'h5
	} esr_mode_type;

	typedef enum logic [1:0] {
		ESR_SZ8 = 2'h0,
		ESR_SZ16 = 2'h1,
		ESR_SZ32 = 2'h2,
		ESR_SZ64 = 2'h3
	} esr_size_type;

	typedef struct packed {
		esr_mode_type mode;
		logic segment_size_select;
		logic [ESR_PFX_SLOTS-1:0][7:0] prefix_bytes;
		logic [ESR_PFX_SLOTS-1:0] prefix_present;
		logic ext_present;
		logic [ESR_EXT_W-1:0] register_extension_prefix;
		logic byte_operand;
		logic ip_relative;
		logic [ESR_DISP_W-1:0] disp;
		logic [ESR_ADDR_W-1:0] base_offset;
		logic [ESR_ADDR_W-1:0] next_instr_pointer;
	} esr_req_type;

	typedef struct packed {
		esr_size_type op_size;
		esr_size_type addr_size;
		logic wide_operand;
		logic simd_mandatory;
		logic [ESR_ADDR_W-1:0] eff_addr;
	} esr_res_type;

endpackage

// ---- hw/esr_size_core.sv ----
`timescale 1ns/100ps
`default_nettype none
module esr_size_core (
	input wire esr_pkg::esr_req_type req,
	output esr_pkg::esr_size_type op_size,
	output esr_pkg::esr_size_type addr_size,
	output logic wide_operand,
	output logic simd_mandatory
);
	import esr_pkg::*;

	// a repeated prefix is only seen once, so it never toggles back
	function automatic logic has_prefix(input esr_req_type r,
		input logic [7:0] code);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < ESR_PFX_SLOTS; i++) begin
			if (r.prefix_present[i] && r.prefix_bytes[i] == code) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction

	logic pfx_op;
	logic pfx_addr;
	logic simd_ext;
	logic op_toggle;
	logic def_wide;

	always_comb begin
		pfx_op = has_prefix(req, ESR_PFX_OPSIZE);
		pfx_addr = has_prefix(req, ESR_PFX_ADDRSIZE);
		// F2/F3 mark a packed op whose 66 is an opcode extension
		simd_ext = has_prefix(req, ESR_PFX_REPNE) |
			has_prefix(req, ESR_PFX_REP);
		simd_mandatory = simd_ext & pfx_op;
		op_toggle = pfx_op & ~simd_ext;
		wide_operand = req.ext_present &
			req.register_extension_prefix[ESR_WIDE_BIT];
		def_wide = 1'b0;
		op_size = ESR_SZ32;
		addr_size = ESR_SZ32;
		case (req.mode)
			ESR_MODE_LONG64: begin
				addr_size = pfx_addr ? ESR_SZ32 : ESR_SZ64;
				if (wide_operand) begin
					op_size = ESR_SZ64;
				end else if (op_toggle) begin
					op_size = ESR_SZ16;
				end else begin
					op_size = ESR_SZ32;
				end
			end
			ESR_MODE_PROT, ESR_MODE_COMPAT: begin
				def_wide = req.segment_size_select;
				op_size = (def_wide ^ op_toggle) ? ESR_SZ32 : ESR_SZ16;
				addr_size = (def_wide ^ pfx_addr) ? ESR_SZ32 : ESR_SZ16;
			end
			default: begin
				def_wide = 1'b0;
				op_size = op_toggle ? ESR_SZ32 : ESR_SZ16;
				addr_size = pfx_addr ? ESR_SZ32 : ESR_SZ16;
			end
		endcase
		if (req.byte_operand) begin
			op_size = ESR_SZ8;
		end
	end

endmodule
`default_nettype wire

// ---- hw/esr_resolver.sv ----
`timescale 1ns/100ps
`default_nettype none
module esr_resolver #(
	parameter int COUNT_W = 32
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [esr_pkg::ESR_APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic req_valid,
	input wire esr_pkg::esr_req_type req,
	output logic res_valid,
	output esr_pkg::esr_res_type res
);
	import esr_pkg::*;

	function automatic logic [ESR_ADDR_W-1:0] trim_addr(
		input logic [ESR_ADDR_W-1:0] a,
		input esr_size_type sz);
		logic [ESR_ADDR_W-1:0] t;
		t = a;
		case (sz)
			ESR_SZ16: begin
				t = {48'h0, a[15:0]};
			end
			ESR_SZ32: begin
				t = {32'h0, a[31:0]};
			end
			default: begin
				t = a;
			end
		endcase
		return t;
	endfunction

	function automatic logic [ESR_ADDR_W-1:0] sext_disp(
		input logic [ESR_DISP_W-1:0] d,
		input esr_size_type sz);
		logic [ESR_ADDR_W-1:0] e;
		e = {{(ESR_ADDR_W-ESR_DISP_W){d[ESR_DISP_W-1]}}, d};
		if (sz == ESR_SZ16) begin
			e = {{48{d[15]}}, d[15:0]};
		end
		return e;
	endfunction

	function automatic logic addr_hit(
		input logic [ESR_APB_AW-1:0] a);
		logic h;
		h = 1'b0;
		case (a)
			ESR_CTRL_OFF, ESR_STATUS_OFF, ESR_COUNT_OFF,
			ESR_WIDE_OFF, ESR_EA_LO_OFF, ESR_EA_HI_OFF: begin
				h = 1'b1;
			end
			default: begin
				h = 1'b0;
			end
		endcase
		return h;
	endfunction

	esr_size_type core_op;
	esr_size_type core_addr;
	logic core_wide;
	logic core_simd;

	esr_size_core u_core (
		.req(req),
		.op_size(core_op),
		.addr_size(core_addr),
		.wide_operand(core_wide),
		.simd_mandatory(core_simd)
	);

	logic [31:0] ctrl_reg;
	logic [31:0] status_reg;
	logic [31:0] status_next;
	logic [COUNT_W-1:0] count_reg;
	logic [COUNT_W-1:0] wide_count_reg;
	logic [ESR_ADDR_W-1:0] last_ea_reg;
	logic res_valid_reg;
	esr_res_type res_reg;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;

	logic enable;
	logic take;
	logic drop;
	logic setup_phase;
	logic wr_commit;
	logic status_w1c;
	logic count_clear;
	logic [ESR_ADDR_W-1:0] base_sel;
	logic [ESR_ADDR_W-1:0] ea_next;
	logic [31:0] read_mux;

	assign enable = ctrl_reg[ESR_CTRL_ENABLE_BIT];
	assign take = req_valid & enable;
	assign drop = req_valid & ~enable;
	assign setup_phase = psel & ~penable;
	assign wr_commit = psel & penable & pready_reg & pwrite;
	assign status_w1c = wr_commit & (paddr == ESR_STATUS_OFF);
	assign count_clear = ctrl_reg[ESR_CTRL_CLEAR_BIT];

	// address generation; result width follows the address attribute
	always_comb begin
		if (req.mode == ESR_MODE_LONG64 && req.ip_relative) begin
			base_sel = req.next_instr_pointer;
		end else begin
			base_sel = trim_addr(req.base_offset, core_addr);
		end
		ea_next = trim_addr(base_sel + sext_disp(req.disp, core_addr),
			core_addr);
	end

	// each request is resolved alone; nothing of a prefix is kept
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res_valid_reg <= 1'b0;
		end else begin
			res_valid_reg <= take;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res_reg <= '0;
		end else if (take) begin
			res_reg.op_size <= core_op;
			res_reg.addr_size <= core_addr;
			res_reg.wide_operand <= core_wide;
			res_reg.simd_mandatory <= core_simd;
			res_reg.eff_addr <= ea_next;
		end
	end

	// clear bit is a one-shot: it drops itself the cycle after
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= ESR_CTRL_RESET;
		end else if (wr_commit && paddr == ESR_CTRL_OFF) begin
			ctrl_reg <= {30'h0, pwdata[ESR_CTRL_CLEAR_BIT],
				pwdata[ESR_CTRL_ENABLE_BIT]};
		end else begin
			ctrl_reg[ESR_CTRL_CLEAR_BIT] <= 1'b0;
		end
	end

	always_comb begin
		status_next = status_reg;
		if (take) begin
			status_next[ESR_ST_OP_LSB +: 2] = core_op;
			status_next[ESR_ST_ADDR_LSB +: 2] = core_addr;
			status_next[ESR_ST_MODE_LSB +: 3] = req.mode;
			status_next[ESR_ST_WIDE_BIT] = core_wide;
		end
		if (status_w1c && pwdata[ESR_ST_DROP_BIT]) begin
			status_next[ESR_ST_DROP_BIT] = 1'b0;
		end
		// a drop in the clearing cycle still shows
		if (drop) begin
			status_next[ESR_ST_DROP_BIT] = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_reg <= 32'h0;
		end else begin
			status_reg <= status_next;
		end
	end

	// counters wrap; software reads differences
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg <= '0;
		end else if (count_clear) begin
			count_reg <= '0;
		end else if (take) begin
			count_reg <= count_reg + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wide_count_reg <= '0;
		end else if (count_clear) begin
			wide_count_reg <= '0;
		end else if (take && core_op == ESR_SZ64) begin
			wide_count_reg <= wide_count_reg + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_ea_reg <= '0;
		end else if (take) begin
			last_ea_reg <= ea_next;
		end
	end

	always_comb begin
		read_mux = 32'h0;
		case (paddr)
			ESR_CTRL_OFF: begin
				read_mux = ctrl_reg;
			end
			ESR_STATUS_OFF: begin
				read_mux = status_reg;
			end
			ESR_COUNT_OFF: begin
				read_mux = 32'(count_reg);
			end
			ESR_WIDE_OFF: begin
				read_mux = 32'(wide_count_reg);
			end
			ESR_EA_LO_OFF: begin
				read_mux = last_ea_reg[31:0];
			end
			ESR_EA_HI_OFF: begin
				read_mux = last_ea_reg[63:32];
			end
			default: begin
				read_mux = 32'h0;
			end
		endcase
	end

	// ready raised from the setup edge so it stays a flop output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
		end else begin
			pready_reg <= setup_phase & ~pready_reg;
		end
	end

	// read data is captured at the setup edge, one cycle early
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0;
		end else if (setup_phase && !pwrite) begin
			prdata_reg <= read_mux;
		end else if (!psel) begin
			prdata_reg <= 32'h0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr_reg <= 1'b0;
		end else if (setup_phase) begin
			pslverr_reg <= ~addr_hit(paddr);
		end else if (pready_reg) begin
			pslverr_reg <= 1'b0;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign res_valid = res_valid_reg;
	assign res = res_reg;

endmodule
`default_nettype wire

// ---- testbench/esr_resolver_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module esr_resolver_chk #(
	parameter int COUNT_W = 32
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic req_valid,
	input wire esr_pkg::esr_req_type req,
	input wire logic res_valid,
	input wire esr_pkg::esr_res_type res
);
	import esr_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic plain;
	logic [63:0] ip_sum;
	assign plain = req_valid && req.prefix_present == '0 && !req.byte_operand;
	assign ip_sum = req.next_instr_pointer + {{32{req.disp[31]}}, req.disp};
	AST_ANSWER: assert property (res_valid |-> $past(req_valid))
		else $error("result without request");
	AST_PROT: assert property (plain && req.mode == ESR_MODE_PROT |=>
		!res_valid || res.op_size == ($past(req.segment_size_select) ?
		ESR_SZ32 : ESR_SZ16)) else $error("protected default wrong");
	AST_LEGACY: assert property (plain && req.mode inside {ESR_MODE_REAL,
		ESR_MODE_V86, ESR_MODE_SYS_MANAGE} |=> !res_valid ||
		res.addr_size == ESR_SZ16) else $error("legacy default wrong");
	AST_LONG: assert property (plain && !req.ext_present &&
		req.mode == ESR_MODE_LONG64 |=> !res_valid ||
		res.op_size == ESR_SZ32 && res.addr_size == ESR_SZ64)
		else $error("long default wrong");
	AST_WIDE: assert property (req_valid && req.mode == ESR_MODE_LONG64 &&
		req.ext_present && req.register_extension_prefix[ESR_WIDE_BIT] &&
		!req.byte_operand |=> !res_valid || res.op_size == ESR_SZ64)
		else $error("wide operand ignored");
	AST_NO_ADDR16: assert property (res_valid &&
		$past(req.mode) == ESR_MODE_LONG64 |-> res.addr_size != ESR_SZ16)
		else $error("16-bit address in long mode");
	AST_IP_REL: assert property (plain && req.ip_relative &&
		req.mode == ESR_MODE_LONG64 |=> !res_valid ||
		res.eff_addr == $past(ip_sum)) else $error("relative address wrong");
	AST_BYTE: assert property (req_valid && req.byte_operand |=>
		!res_valid || res.op_size == ESR_SZ8) else $error("byte size wrong");
	AST_READY: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	AST_ERR: assert property (pslverr |-> pready && $past(psel))
		else $error("stray error");
endmodule
bind esr_resolver esr_resolver_chk #(.COUNT_W(COUNT_W)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr), .req_valid(req_valid), .req(req),
	.res_valid(res_valid), .res(res));
`default_nettype wire

// ---- testbench/esr_fetch_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module esr_fetch_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic go,
	input wire esr_pkg::esr_req_type next_req,
	output logic req_valid,
	output esr_pkg::esr_req_type req
);
	import esr_pkg::*;
	// idle fields invert so stale data never passes for valid
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_valid <= 1'b0;
			req <= '0;
		end else begin
			req_valid <= go;
			req <= go ? next_req : ~req;
		end
	end
endmodule
`default_nettype wire

// ---- testbench/esr_resolver_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module esr_resolver_tb_top;
	import esr_pkg::*;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [ESR_APB_AW-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, er, req_valid, res_valid;
	logic go = 0;
	esr_req_type nreq = '0;
	esr_req_type req;
	esr_res_type res;
	esr_res_type expq[$];
	int mismatches = 0;
	int n_checks = 0;
	int n_acc = 0;
	int n_w64 = 0;
	logic [7:0] pfx [4] = '{8'h66, 8'h67, 8'hF3, 8'h90};
	always #2 pclk = ~pclk;
	esr_fetch_model u_esr_fetch_model (.pclk(pclk), .presetn(presetn),
		.go(go), .next_req(nreq), .req_valid(req_valid), .req(req));
	esr_resolver #(.COUNT_W(32)) u_esr_resolver (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .req_valid(req_valid),
		.req(req), .res_valid(res_valid), .res(res));
	task automatic check(string nm, logic [69:0] s, logic [69:0] e);
		n_checks++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	function automatic esr_res_type model(esr_req_type r);
		esr_res_type x;
		logic p66, p67, pf, w, d;
		logic [63:0] sd, b;
		{p66, p67, pf} = 3'h0;
		for (int i = 0; i < ESR_PFX_SLOTS; i++) begin
			if (r.prefix_present[i]) begin
				p66 |= r.prefix_bytes[i] == ESR_PFX_OPSIZE;
				p67 |= r.prefix_bytes[i] == ESR_PFX_ADDRSIZE;
				pf |= r.prefix_bytes[i] inside {ESR_PFX_REPNE, ESR_PFX_REP};
			end
		end
		w = r.ext_present & r.register_extension_prefix[ESR_WIDE_BIT];
		d = r.segment_size_select & (r.mode inside {ESR_MODE_PROT,
			ESR_MODE_COMPAT});
		sd = {{32{r.disp[31]}}, r.disp};
		x = '0;
		x.wide_operand = w;
		x.simd_mandatory = p66 & pf;
		if (r.mode == ESR_MODE_LONG64) begin
			x.addr_size = p67 ? ESR_SZ32 : ESR_SZ64;
			x.op_size = w ? ESR_SZ64 : (p66 && !pf) ? ESR_SZ16 : ESR_SZ32;
		end else begin
			x.addr_size = (d ^ p67) ? ESR_SZ32 : ESR_SZ16;
			x.op_size = (d ^ (p66 && !pf)) ? ESR_SZ32 : ESR_SZ16;
		end
		if (r.byte_operand) x.op_size = ESR_SZ8;
		b = r.base_offset;
		if (r.mode == ESR_MODE_LONG64 && r.ip_relative) b = r.next_instr_pointer;
		if (x.addr_size == ESR_SZ16) b = {48'h0, b[15:0] + sd[15:0]};
		else if (x.addr_size == ESR_SZ32) b = {32'h0, b[31:0] + sd[31:0]};
		else b = b + sd;
		x.eff_addr = b;
		return x;
	endfunction
	task automatic issue(esr_req_type r, bit take);
		esr_res_type x;
		x = model(r);
		go <= 1'b1;
		nreq <= r;
		if (take) begin
			expq.push_back(x);
			n_acc++;
			n_w64 += (x.op_size == ESR_SZ64);
		end
		@(posedge pclk);
	endtask
	task automatic idle(int n);
		go <= 1'b0;
		repeat (n) @(posedge pclk);
	endtask
	task automatic apb(bit w, logic [ESR_APB_AW-1:0] a, logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			mismatches++;
			report_and_stop();
		end else begin
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	always @(posedge pclk) begin
		if (res_valid === 1'b1) begin
			if (expq.size() == 0) check("extra", 70'h1, 70'h0);
			else check("res", res, expq.pop_front());
		end
	end
	initial begin
		esr_req_type r;
		esr_res_type xl;
		void'($urandom(48934));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, ESR_CTRL_OFF, 0);
		check("ctrl", {er, rd}, {1'b0, ESR_CTRL_RESET});
		$display("test reset done");
		// every mode against every prefix mix, repeated 66H in two slots
		for (int i = 0; i < 96; i++) begin
			r = '0;
			r.mode = esr_mode_type'(3'((i % 48) >> 3));
			r.prefix_bytes = {ESR_PFX_REPNE, ESR_PFX_ADDRSIZE,
				ESR_PFX_OPSIZE, ESR_PFX_OPSIZE};
			r.prefix_present = {i >= 48, i[1], i[0] & i[2], i[0]};
			r.segment_size_select = i[2];
			r.ext_present = r.mode == ESR_MODE_LONG64;
			r.register_extension_prefix = {i[2], 3'h5};
			// negative displacement so every trim and sign extension shows
			r.ip_relative = i[3];
			r.disp = 32'hFFFF_FFF0;
			r.base_offset = 64'h1234_5678_9ABC_DEF0;
			r.next_instr_pointer = 64'h0000_0001_0000_0008;
			issue(r, 1);
		end
		idle(3);
		$display("test table done");
		for (int i = 0; i < 300; i++) begin
			r.mode = esr_mode_type'(3'($urandom_range(0, 7)));
			r.segment_size_select = 1'($urandom);
			for (int k = 0; k < 4; k++) r.prefix_bytes[k] = pfx[$urandom_range(0, 3)];
			r.prefix_present = 4'($urandom);
			r.ext_present = r.mode == ESR_MODE_LONG64 && 1'($urandom);
			r.register_extension_prefix = 4'($urandom);
			r.byte_operand = $urandom_range(0, 7) == 0;
			r.ip_relative = 1'($urandom);
			r.disp = $urandom;
			r.base_offset = {$urandom, $urandom};
			r.next_instr_pointer = {$urandom, $urandom};
			issue(r, 1);
		end
		idle(3);
		$display("test random done");
		apb(0, ESR_COUNT_OFF, 0);
		check("count", {er, rd}, {1'b0, 32'(n_acc)});
		apb(0, ESR_WIDE_OFF, 0);
		check("wide", {er, rd}, {1'b0, 32'(n_w64)});
		apb(0, ESR_EA_LO_OFF, 0);
		xl = model(r);
		check("ea", rd, 70'(xl.eff_addr[31:0]));
		apb(1, ESR_CTRL_OFF, 0);
		issue(r, 0);
		idle(3);
		apb(0, ESR_STATUS_OFF, 0);
		check("drop", rd[ESR_ST_DROP_BIT], 1'b1);
		check("status", rd[9:0], {xl.wide_operand, 2'h2, r.mode,
			xl.addr_size, xl.op_size});
		apb(1, ESR_STATUS_OFF, 32'h100);
		apb(0, ESR_STATUS_OFF, 0);
		check("w1c", rd[ESR_ST_DROP_BIT], 1'b0);
		apb(1, ESR_CTRL_OFF, 32'h3);
		apb(0, ESR_COUNT_OFF, 0);
		check("clear", {er, rd}, 33'h0);
		apb(0, ESR_CTRL_OFF, 0);
		check("self clear", {er, rd}, {1'b0, ESR_CTRL_RESET});
		apb(0, 8'h18, 0);
		check("unmapped", {er, rd}, {1'b1, 32'h0});
		check("queue", expq.size(), 0);
		$display("test registers done");
		report_and_stop();
	end
endmodule
`default_nettype wire
